/* include/pss_map.svh */
// Register offsets, field positions, reset values and timing figures of
// the start-up sequencer. Assumes a 125 MHz system clock.
`ifndef PSS_MAP_SVH
`define PSS_MAP_SVH

// -----------------------------------------------------------------------
// Register byte offsets
// -----------------------------------------------------------------------
`define PSS_CTRL_OFS 8'h00
`define PSS_STATUS_OFS 8'h04
`define PSS_CLASS_OFS 8'h08

// -----------------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------------
`define PSS_CTRL_EN_BIT 0
`define PSS_CTRL_REQ_LSB 4
`define PSS_ST_STATE_LSB 0
`define PSS_ST_PG_BIT 2
`define PSS_ST_HIPWR_BIT 3
`define PSS_ST_ABORT_BIT 4
`define PSS_ST_PIN_LSB 8
`define PSS_CL_ASG_LSB 0
`define PSS_CL_HI_BIT 4
`define PSS_CL_LO_BIT 5
`define PSS_CL_SRC_BIT 6

// -----------------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------------
`define PSS_CTRL_RST 32'h0000_0041

// -----------------------------------------------------------------------
// Timing
// -----------------------------------------------------------------------
`define PSS_CLK_HZ 64'd125000000
`define PSS_HIPWR_MS 64'd80
`define PSS_INRUSH_MAX_MS 64'd100
`define PSS_MS_TO_CYC(ms) (((ms) * `PSS_CLK_HZ) / 64'd1000)

`endif

/* include/pss_pkg.sv */
// Types shared by the start-up sequencer modules.
// Assumes nothing beyond a SystemVerilog compiler.
package pss_pkg;

   // --------------------------------------------------------------------
   // Sequencer states
   // --------------------------------------------------------------------
   typedef enum logic [1:0] {
      PSS_IDLE = 2'b00,
      PSS_INRUSH = 2'b01,
      PSS_NORMAL = 2'b10,
      PSS_FAULT = 2'b11
   } pss_state_t;

   typedef logic [3:0] pss_class_t;

endpackage

/* include/pss_sync_if.sv */
// Bundle of raw pin levels and their synchronised copies.
// Assumes both ends run on the same system clock.
interface pss_sync_if #(
   parameter int W = 1
);
   logic [W-1:0] raw;
   logic [W-1:0] synced;

   modport syn (input raw, output synced);
   modport user (output raw, input synced);
endinterface

/* core/pss_sync.sv */
// Two-stage synchroniser for a group of pin levels.
// Assumes the pins are quasi-static relative to the system clock.
module pss_sync (
   input wire logic clk_in,
   input wire logic rst_n_in,
   pss_sync_if.syn bus
);
   logic [$bits(bus.raw)-1:0] stage1;
   logic [$bits(bus.raw)-1:0] stage2;

   // --------------------------------------------------------------------
   // Synchroniser stages
   // --------------------------------------------------------------------
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         stage1 <= '0;
         stage2 <= '0;
      end else begin
         stage1 <= bus.raw;
         stage2 <= stage1;
      end
   end

   assign bus.synced = stage2;
endmodule

/* core/pss_top.sv */
// Start-up sequencer of a powered-device interface with AXI4-Lite access.
// Assumes analog comparators and the classification engine drive the pins.
// Notes on behaviour
// RULE_01 - Enter inrush once port passes upper threshold after classification.
// RULE_02 - Leave inrush for normal only with return node low and gate high.
// RULE_03 - Abort inrush when capacitance stays uncharged too long.
// RULE_04 - Class 1 and 2 systems run at class power 50 ms after threshold.
// RULE_05 - Power-good output is driven low throughout inrush.
// RULE_06 - System keeps converter and big loads off while power-good low.
// RULE_07 - On leaving inrush, float power-good, stop limiting, keep switch on.
// RULE_08 - System starts at class 3 or less, more only when assigned.
// RULE_09 - Class 4 or above power only 80 ms after threshold crossing.
// RULE_10 - Requested class 4 to 6 decode onto high and low result outputs.
// RULE_11 - Requested class 7 and 8 decode onto high and low result outputs.
// RULE_12 - Class 8 above 71.3 W only with known cable, under 90 W.
// RULE_13 - System always stays at or below its assigned power.
// RULE_14 - Source-type flag floats for type 1/2, driven low for type 3/4.
// RULE_15 - Signature pulses meet minimum length and maximum dropout.
// RULE_16 - Signature timing follows the source-type flag.
// RULE_17 - Signature current is 10 mA up to class 4, else 16 mA.
// RULE_18 - Signature begins at threshold crossing; inrush may count.
// RULE_19 - With autoclass and flag low, full power from 1.35 s to 3.65 s.
// RULE_20 - System pulls up open-drain outputs; float reads high.
`include "pss_map.svh"
module pss_top
   import pss_pkg::*;
#(
   parameter int AW = 8,
   parameter logic [31:0] HIPWR_CYC = 32'(`PSS_MS_TO_CYC(`PSS_HIPWR_MS)),
   parameter logic [31:0] INRUSH_CYC =
      32'(`PSS_MS_TO_CYC(`PSS_INRUSH_MAX_MS))
) (
   input wire logic CLK_IN,
   input wire logic RST_N_IN,
   input wire logic UPPER_THRESH_ABOVE_IN,
   input wire logic CLASS_DONE_IN,
   input wire logic RETURN_LOW_IN,
   input wire logic GATE_HIGH_IN,
   input wire logic SRC_TYPE34_IN,
   input wire logic [3:0] ASSIGNED_CLASS_IN,
   input wire logic POWER_GOOD_IN,
   input wire logic CLASS_RESULT_HIGH_IN,
   input wire logic CLASS_RESULT_LOW_IN,
   input wire logic SOURCE_TYPE_FLAG_IN,
   output logic POWER_GOOD_OUT,
   output logic POWER_GOOD_OE_OUT,
   output logic CLASS_RESULT_HIGH_OUT,
   output logic CLASS_RESULT_HIGH_OE_OUT,
   output logic CLASS_RESULT_LOW_OUT,
   output logic CLASS_RESULT_LOW_OE_OUT,
   output logic SOURCE_TYPE_FLAG_OUT,
   output logic SOURCE_TYPE_FLAG_OE_OUT,
   output logic PASS_SWITCH_ON_OUT,
   output logic CURRENT_LIMIT_OUT,
   input wire logic [AW-1:0] S_AXI_AWADDR_IN,
   input wire logic S_AXI_AWVALID_IN,
   output logic S_AXI_AWREADY_OUT,
   input wire logic [31:0] S_AXI_WDATA_IN,
   input wire logic [3:0] S_AXI_WSTRB_IN,
   input wire logic S_AXI_WVALID_IN,
   output logic S_AXI_WREADY_OUT,
   output logic [1:0] S_AXI_BRESP_OUT,
   output logic S_AXI_BVALID_OUT,
   input wire logic S_AXI_BREADY_IN,
   input wire logic [AW-1:0] S_AXI_ARADDR_IN,
   input wire logic S_AXI_ARVALID_IN,
   output logic S_AXI_ARREADY_OUT,
   output logic [31:0] S_AXI_RDATA_OUT,
   output logic [1:0] S_AXI_RRESP_OUT,
   output logic S_AXI_RVALID_OUT,
   input wire logic S_AXI_RREADY_IN
);
   pss_sync_if #(.W(13)) pins ();
   pss_state_t state;
   pss_state_t next_state;
   logic uvlo;
   logic cdone;
   logic ret_low;
   logic gate_high;
   logic src34;
   pss_class_t asg;
   logic [3:0] pin_lvl;
   logic [31:0] inrush_cnt;
   logic [31:0] up_cnt;
   logic hipwr_ok;
   logic abort_flag;
   logic enable;
   pss_class_t req;
   pss_class_t asg_held;
   logic hi_drive;
   logic lo_drive;
   logic aw_full;
   logic w_full;
   logic [AW-1:0] aw_addr;
   logic [31:0] w_data;
   logic w_strb0;
   logic wr_do;
   logic abort_clr;
   logic [31:0] rd_mux;
   logic rd_ok;

   // --------------------------------------------------------------------
   // Pin synchronisation
   // --------------------------------------------------------------------
   assign pins.raw = {POWER_GOOD_IN, CLASS_RESULT_HIGH_IN,
                      CLASS_RESULT_LOW_IN, SOURCE_TYPE_FLAG_IN,
                      ASSIGNED_CLASS_IN, SRC_TYPE34_IN, GATE_HIGH_IN,
                      RETURN_LOW_IN, CLASS_DONE_IN, UPPER_THRESH_ABOVE_IN};
   assign {pin_lvl, asg, src34, gate_high, ret_low, cdone, uvlo} =
      pins.synced;

   pss_sync u_sync (
      .clk_in(CLK_IN),
      .rst_n_in(RST_N_IN),
      .bus(pins)
   );

   // --------------------------------------------------------------------
   // Sequencer
   // --------------------------------------------------------------------
   always_comb begin
      next_state = state;
      unique case (state)
         PSS_IDLE: begin
            if (enable && uvlo && cdone) begin
               next_state = PSS_INRUSH; // [RULE_01]
            end
         end
         PSS_INRUSH: begin
            if (!uvlo) begin
               next_state = PSS_IDLE;
            end else if (ret_low && gate_high) begin
               next_state = PSS_NORMAL; // [RULE_02]
            end else if (inrush_cnt >= INRUSH_CYC - 32'd1) begin
               next_state = PSS_FAULT; // [RULE_03]
            end
         end
         PSS_NORMAL: begin
            if (!uvlo) begin
               next_state = PSS_IDLE;
            end
         end
         PSS_FAULT: begin
            if (!uvlo) begin
               next_state = PSS_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         state <= PSS_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Inrush timer measures time spent charging the port capacitance.
   always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         inrush_cnt <= 32'h0000_0000;
      end else if (state == PSS_INRUSH) begin
         inrush_cnt <= inrush_cnt + 32'd1; // [RULE_03]
      end else begin
         inrush_cnt <= 32'h0000_0000;
      end
   end

   // Time since the upper threshold crossing, saturating at the limit.
   always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         up_cnt <= 32'h0000_0000;
         hipwr_ok <= 1'b0;
      end else if (!uvlo) begin
         up_cnt <= 32'h0000_0000;
         hipwr_ok <= 1'b0;
      end else if (up_cnt >= HIPWR_CYC - 32'd1) begin
         hipwr_ok <= 1'b1; // [RULE_09]
      end else begin
         up_cnt <= up_cnt + 32'd1;
      end
   end

   // --------------------------------------------------------------------
   // Pin drivers
   // --------------------------------------------------------------------
   always_comb begin
      hi_drive = 1'b0;
      lo_drive = 1'b0;
      if (req >= 4'h4 && req <= 4'h6) begin
         hi_drive = asg >= 4'h5; // [RULE_10]
         lo_drive = asg == 4'h4; // [RULE_10]
      end else if (req >= 4'h7) begin
         hi_drive = asg >= 4'h6; // [RULE_11]
         lo_drive = asg == 4'h4 || asg >= 4'h7; // [RULE_11]
      end
   end

   always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         POWER_GOOD_OE_OUT <= 1'b1;
         PASS_SWITCH_ON_OUT <= 1'b0;
         CURRENT_LIMIT_OUT <= 1'b0;
      end else begin
         POWER_GOOD_OE_OUT <= next_state != PSS_NORMAL; // [RULE_05] [RULE_07]
         PASS_SWITCH_ON_OUT <= next_state == PSS_INRUSH ||
                               next_state == PSS_NORMAL; // [RULE_07]
         CURRENT_LIMIT_OUT <= next_state == PSS_INRUSH; // [RULE_07]
      end
   end

   // Results are captured as inrush starts; the pin enables drop on power loss, asg_held is kept.
   always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         CLASS_RESULT_HIGH_OE_OUT <= 1'b0;
         CLASS_RESULT_LOW_OE_OUT <= 1'b0;
         SOURCE_TYPE_FLAG_OE_OUT <= 1'b0;
         asg_held <= 4'h0;
      end else if (state == PSS_IDLE && next_state == PSS_INRUSH) begin
         CLASS_RESULT_HIGH_OE_OUT <= hi_drive; // [RULE_10] [RULE_11]
         CLASS_RESULT_LOW_OE_OUT <= lo_drive; // [RULE_10] [RULE_11]
         SOURCE_TYPE_FLAG_OE_OUT <= src34; // [RULE_14]
         asg_held <= asg;
      end else if (next_state == PSS_IDLE) begin
         CLASS_RESULT_HIGH_OE_OUT <= 1'b0;
         CLASS_RESULT_LOW_OE_OUT <= 1'b0;
         SOURCE_TYPE_FLAG_OE_OUT <= 1'b0;
      end
   end

   // Open-drain outputs only ever pull low.
   always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         POWER_GOOD_OUT <= 1'b0;
         CLASS_RESULT_HIGH_OUT <= 1'b0;
         CLASS_RESULT_LOW_OUT <= 1'b0;
         SOURCE_TYPE_FLAG_OUT <= 1'b0;
      end else begin
         POWER_GOOD_OUT <= 1'b0;
         CLASS_RESULT_HIGH_OUT <= 1'b0;
         CLASS_RESULT_LOW_OUT <= 1'b0;
         SOURCE_TYPE_FLAG_OUT <= 1'b0;
      end
   end

   // --------------------------------------------------------------------
   // Register bus
   // --------------------------------------------------------------------
   assign wr_do = aw_full && w_full && !S_AXI_BVALID_OUT;
   assign abort_clr = wr_do && w_strb0 && w_data[`PSS_ST_ABORT_BIT] &&
                      aw_addr[3:2] == `PSS_STATUS_OFS >> 2 &&
                      aw_addr[AW-1:4] == '0;

   always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         aw_full <= 1'b0;
         S_AXI_AWREADY_OUT <= 1'b1;
         aw_addr <= '0;
      end else if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT) begin
         aw_full <= 1'b1;
         S_AXI_AWREADY_OUT <= 1'b0;
         aw_addr <= S_AXI_AWADDR_IN;
      end else if (wr_do) begin
         aw_full <= 1'b0;
         S_AXI_AWREADY_OUT <= 1'b1;
      end
   end

   always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         w_full <= 1'b0;
         S_AXI_WREADY_OUT <= 1'b1;
         w_data <= 32'h0000_0000;
         w_strb0 <= 1'b0;
      end else if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT) begin
         w_full <= 1'b1;
         S_AXI_WREADY_OUT <= 1'b0;
         w_data <= S_AXI_WDATA_IN;
         w_strb0 <= S_AXI_WSTRB_IN[0];
      end else if (wr_do) begin
         w_full <= 1'b0;
         S_AXI_WREADY_OUT <= 1'b1;
      end
   end

   always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         S_AXI_BVALID_OUT <= 1'b0;
         S_AXI_BRESP_OUT <= 2'h0;
         enable <= 1'(`PSS_CTRL_RST >> `PSS_CTRL_EN_BIT);
         req <= 4'(`PSS_CTRL_RST >> `PSS_CTRL_REQ_LSB);
      end else if (wr_do) begin
         S_AXI_BVALID_OUT <= 1'b1;
         S_AXI_BRESP_OUT <= 2'h0;
         if (aw_addr[AW-1:4] != '0 || aw_addr[3:2] == 2'h3) begin
            S_AXI_BRESP_OUT <= 2'h3;
         end else if (aw_addr[3:2] == `PSS_CTRL_OFS >> 2 && w_strb0) begin
            enable <= w_data[`PSS_CTRL_EN_BIT];
            req <= w_data[`PSS_CTRL_REQ_LSB +: 4];
         end
      end else if (S_AXI_BREADY_IN) begin
         S_AXI_BVALID_OUT <= 1'b0;
      end
   end

   // Sticky abort flag; a new abort wins over a clear in the same cycle.
   always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         abort_flag <= 1'b0;
      end else if (state == PSS_INRUSH && next_state == PSS_FAULT) begin
         abort_flag <= 1'b1; // [RULE_03]
      end else if (abort_clr) begin
         abort_flag <= 1'b0;
      end
   end

   always_comb begin
      rd_mux = 32'h0000_0000;
      rd_ok = S_AXI_ARADDR_IN[AW-1:4] == '0;
      unique case (S_AXI_ARADDR_IN[3:2])
         2'h0: begin
            rd_mux[`PSS_CTRL_EN_BIT] = enable;
            rd_mux[`PSS_CTRL_REQ_LSB +: 4] = req;
         end
         2'h1: begin
            rd_mux[`PSS_ST_STATE_LSB +: 2] = state;
            rd_mux[`PSS_ST_PG_BIT] = !POWER_GOOD_OE_OUT;
            rd_mux[`PSS_ST_HIPWR_BIT] = hipwr_ok;
            rd_mux[`PSS_ST_ABORT_BIT] = abort_flag;
            rd_mux[`PSS_ST_PIN_LSB +: 4] = pin_lvl;
         end
         2'h2: begin
            rd_mux[`PSS_CL_ASG_LSB +: 4] = asg_held;
            rd_mux[`PSS_CL_HI_BIT] = CLASS_RESULT_HIGH_OE_OUT;
            rd_mux[`PSS_CL_LO_BIT] = CLASS_RESULT_LOW_OE_OUT;
            rd_mux[`PSS_CL_SRC_BIT] = SOURCE_TYPE_FLAG_OE_OUT;
         end
         2'h3: begin
            rd_ok = 1'b0;
         end
      endcase
   end

   always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         S_AXI_ARREADY_OUT <= 1'b1;
         S_AXI_RVALID_OUT <= 1'b0;
         S_AXI_RDATA_OUT <= 32'h0000_0000;
         S_AXI_RRESP_OUT <= 2'h0;
      end else if (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT) begin
         S_AXI_ARREADY_OUT <= 1'b0;
         S_AXI_RVALID_OUT <= 1'b1;
         S_AXI_RDATA_OUT <= rd_ok ? rd_mux : 32'h0000_0000;
         S_AXI_RRESP_OUT <= rd_ok ? 2'h0 : 2'h3;
      end else if (S_AXI_RVALID_OUT && S_AXI_RREADY_IN) begin
         S_AXI_ARREADY_OUT <= 1'b1;
         S_AXI_RVALID_OUT <= 1'b0;
      end
   end
endmodule

/* sim/pss_assertions.sv */
// Concurrent checks on the ports of the start-up sequencer.
// Assumes one clock domain and an active-low asynchronous reset.
module pss_assertions #(
   parameter logic [31:0] INRUSH_CYC = 32'd40
) (
   input wire logic CLK_IN,
   input wire logic RST_N_IN,
   input wire logic UPPER_THRESH_ABOVE_IN,
   input wire logic CLASS_DONE_IN,
   input wire logic RETURN_LOW_IN,
   input wire logic GATE_HIGH_IN,
   input wire logic SRC_TYPE34_IN,
   input wire logic POWER_GOOD_OE_OUT,
   input wire logic SOURCE_TYPE_FLAG_OE_OUT,
   input wire logic PASS_SWITCH_ON_OUT,
   input wire logic CURRENT_LIMIT_OUT,
   input wire logic S_AXI_ARVALID_IN,
   input wire logic S_AXI_ARREADY_OUT,
   input wire logic S_AXI_RVALID_OUT,
   input wire logic S_AXI_BVALID_OUT,
   input wire logic S_AXI_BREADY_IN
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] dwell;
   default clocking @(posedge CLK_IN);
   endclocking
   default disable iff (!RST_N_IN);
   // ---------------------------------------------------------------------
   // Cycles spent with the inrush limit active.
   // ---------------------------------------------------------------------
   always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         dwell <= 32'h0;
      end else begin
         dwell <= CURRENT_LIMIT_OUT ? dwell + 32'h1 : 32'h0;
      end
   end
   property p_entry;
      $rose(CURRENT_LIMIT_OUT) |-> $past(UPPER_THRESH_ABOVE_IN, 3) &&
         $past(CLASS_DONE_IN, 3);
   endproperty
   a_entry: assert property (p_entry)
      else $error("inrush entered without cause");
   property p_exit;
      $fell(CURRENT_LIMIT_OUT) && PASS_SWITCH_ON_OUT |->
         $past(RETURN_LOW_IN, 3) && $past(GATE_HIGH_IN, 3);
   endproperty
   a_exit: assert property (p_exit)
      else $error("normal entered without cause");
   property p_abort;
      dwell <= INRUSH_CYC + 32'h1;
   endproperty
   a_abort: assert property (p_abort)
      else $error("inrush not aborted in time");
   property p_pg_low;
      CURRENT_LIMIT_OUT |-> POWER_GOOD_OE_OUT;
   endproperty
   a_pg_low: assert property (p_pg_low)
      else $error("power good released in inrush");
   property p_release;
      PASS_SWITCH_ON_OUT && !CURRENT_LIMIT_OUT |-> !POWER_GOOD_OE_OUT;
   endproperty
   a_release: assert property (p_release)
      else $error("power good held in normal");
   property p_flag;
      $rose(CURRENT_LIMIT_OUT) |->
         SOURCE_TYPE_FLAG_OE_OUT == $past(SRC_TYPE34_IN, 3);
   endproperty
   a_flag: assert property (p_flag)
      else $error("source flag wrong");
   property p_drop;
      !UPPER_THRESH_ABOVE_IN [*3] |=>
         !PASS_SWITCH_ON_OUT && !CURRENT_LIMIT_OUT;
   endproperty
   a_drop: assert property (p_drop)
      else $error("switch on without port voltage");
   property p_bhold;
      S_AXI_BVALID_OUT && !S_AXI_BREADY_IN |=> S_AXI_BVALID_OUT;
   endproperty
   a_bhold: assert property (p_bhold)
      else $error("write response dropped");
   property p_rans;
      S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT |=> S_AXI_RVALID_OUT;
   endproperty
   a_rans: assert property (p_rans)
      else $error("read answer late");
endmodule

bind pss_top pss_assertions #(.INRUSH_CYC(INRUSH_CYC)) u_chk (
   .CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN),
   .UPPER_THRESH_ABOVE_IN(UPPER_THRESH_ABOVE_IN),
   .CLASS_DONE_IN(CLASS_DONE_IN),
   .RETURN_LOW_IN(RETURN_LOW_IN), .GATE_HIGH_IN(GATE_HIGH_IN),
   .SRC_TYPE34_IN(SRC_TYPE34_IN), .POWER_GOOD_OE_OUT(POWER_GOOD_OE_OUT),
   .SOURCE_TYPE_FLAG_OE_OUT(SOURCE_TYPE_FLAG_OE_OUT),
   .PASS_SWITCH_ON_OUT(PASS_SWITCH_ON_OUT),
   .CURRENT_LIMIT_OUT(CURRENT_LIMIT_OUT),
   .S_AXI_ARVALID_IN(S_AXI_ARVALID_IN),
   .S_AXI_ARREADY_OUT(S_AXI_ARREADY_OUT),
   .S_AXI_RVALID_OUT(S_AXI_RVALID_OUT),
   .S_AXI_BVALID_OUT(S_AXI_BVALID_OUT), .S_AXI_BREADY_IN(S_AXI_BREADY_IN)
);

/* sim/pss_pse_model.sv */
// Source equipment across the cable, with the pull-ups of the status pins.
// Assumes the bench commands power and the classification outcome.
module pss_pse_model
   import pss_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic power_in,
   input wire logic type34_in,
   input wire pss_class_t class_in,
   input wire logic [3:0] oe_in,
   output logic uvlo_out,
   output logic done_out,
   output logic type34_out,
   output pss_class_t class_out,
   output logic [3:0] pin_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] ramp;
   // A pulled-up line reads high unless the device drives it.
   assign pin_out = ~oe_in;
   // Classification completes before the port voltage rises.
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ramp <= 3'h0;
         uvlo_out <= 1'b0;
         done_out <= 1'b0;
         type34_out <= 1'b0;
         class_out <= 4'h0;
      end else if (!power_in) begin
         ramp <= 3'h0;
         uvlo_out <= 1'b0;
         done_out <= 1'b0;
      end else begin
         done_out <= 1'b1;
         type34_out <= type34_in;
         class_out <= class_in;
         ramp <= (ramp == 3'h4) ? ramp : ramp + 3'h1;
         uvlo_out <= (ramp == 3'h4);
      end
   end
endmodule

/* sim/testbench.sv */
// Self-checking bench of the sequencer with register and pin stimulus.
// Assumes the source model and the port checker are compiled alongside.
`include "pss_map.svh"
module testbench
   import pss_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] INR = 32'd40;
   localparam logic [31:0] HIP = 32'd50;
   logic clk = 1'b0, rst_n = 1'b0, power = 1'b0, type34 = 1'b0;
   logic ret = 1'b0, gate = 1'b0, uvlo, done, t34, pass, limit;
   pss_class_t cls = 4'h0, asg;
   logic [3:0] pin, oe, od;
   logic [7:0] awaddr = 8'h0, araddr = 8'h0;
   logic [31:0] wdata = 32'h0, rdata, rd, ex;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, rs, bs;
   logic [9:0] row [11] = '{10'h033, 10'h043, 10'h144, 10'h255, 10'h266,
      10'h073, 10'h174, 10'h276, 10'h377, 10'h388, 10'h286};
   int num_errors = 0, n_tests = 0;
   always #4 clk = ~clk;
   pss_pse_model u_pse (.clk_in(clk), .rst_n_in(rst_n), .power_in(power),
      .type34_in(type34), .class_in(cls), .oe_in(oe), .uvlo_out(uvlo),
      .done_out(done), .type34_out(t34), .class_out(asg), .pin_out(pin));
   pss_top #(.HIPWR_CYC(HIP), .INRUSH_CYC(INR)) dut (.CLK_IN(clk),
      .RST_N_IN(rst_n), .UPPER_THRESH_ABOVE_IN(uvlo), .CLASS_DONE_IN(done),
      .RETURN_LOW_IN(ret), .GATE_HIGH_IN(gate), .SRC_TYPE34_IN(t34),
      .ASSIGNED_CLASS_IN(asg), .POWER_GOOD_IN(pin[3]),
      .CLASS_RESULT_HIGH_IN(pin[2]), .CLASS_RESULT_LOW_IN(pin[1]),
      .SOURCE_TYPE_FLAG_IN(pin[0]), .POWER_GOOD_OUT(od[3]),
      .POWER_GOOD_OE_OUT(oe[3]), .CLASS_RESULT_HIGH_OUT(od[2]),
      .CLASS_RESULT_HIGH_OE_OUT(oe[2]), .CLASS_RESULT_LOW_OUT(od[1]),
      .CLASS_RESULT_LOW_OE_OUT(oe[1]), .SOURCE_TYPE_FLAG_OUT(od[0]),
      .SOURCE_TYPE_FLAG_OE_OUT(oe[0]), .PASS_SWITCH_ON_OUT(pass),
      .CURRENT_LIMIT_OUT(limit), .S_AXI_AWADDR_IN(awaddr),
      .S_AXI_AWVALID_IN(awvalid), .S_AXI_AWREADY_OUT(awready),
      .S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(4'hf),
      .S_AXI_WVALID_IN(wvalid), .S_AXI_WREADY_OUT(wready),
      .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bvalid),
      .S_AXI_BREADY_IN(bready), .S_AXI_ARADDR_IN(araddr),
      .S_AXI_ARVALID_IN(arvalid), .S_AXI_ARREADY_OUT(arready),
      .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp),
      .S_AXI_RVALID_OUT(rvalid), .S_AXI_RREADY_IN(rready));
   // ---------------------------------------------------------------------
   // Bus cycles, waits and comparison.
   // ---------------------------------------------------------------------
   task automatic chk(input string what, input logic [31:0] seen,
         input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bs = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd32(input logic [7:0] a);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rd = rdata;
      rs = rresp;
      rready <= 1'b0;
   endtask
   task automatic wait_on(ref logic s, input logic v);
      for (int k = 0; k < 80 && s !== v; k++) @(posedge clk);
   endtask
   task automatic end_of_test();
      $display("Comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      end_of_test();
   end
   // ---------------------------------------------------------------------
   // Main sequence.
   // ---------------------------------------------------------------------
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      rd32(`PSS_CTRL_OFS);
      chk("ctrl reset", rd, `PSS_CTRL_RST);
      rd32(`PSS_STATUS_OFS);
      chk("status reset", rd, 32'h0000_0700);
      rd32(8'h0c);
      chk("unmapped resp", rs, 32'h3);
      chk("unmapped data", rd, 32'h0);
      wr(8'h0c, 32'h0000_0000);
      chk("unmapped wresp", bs, 32'h3);
      foreach (row[i]) begin
         type34 <= i[0];
         cls <= row[i][3:0];
         wr(`PSS_CTRL_OFS, {24'h0, row[i][7:4], 4'h1});
         power <= 1'b1;
         wait_on(pass, 1'b1);
         chk("limit", limit, 32'h1);
         chk("pg held", oe[3], 32'h1);
         chk("drain data", od, 32'h0);
         rd32(`PSS_CLASS_OFS);
         ex = {25'h0, i[0], row[i][8], row[i][9], row[i][3:0]};
         chk("class", rd, ex);
         ret <= 1'b1;
         repeat (8) @(posedge clk);
         chk("rtn only", limit, 32'h1);
         gate <= 1'b1;
         wait_on(limit, 1'b0);
         chk("switch kept", pass, 32'h1);
         rd32(`PSS_STATUS_OFS);
         ex = {20'h0, 1'b1, ~row[i][9:8], ~i[0], 8'h06};
         chk("status", rd, ex);
         repeat (40) @(posedge clk);
         rd32(`PSS_STATUS_OFS);
         chk("high power", rd[3], 32'h1);
         power <= 1'b0;
         ret <= 1'b0;
         gate <= 1'b0;
         wait_on(pass, 1'b0);
         repeat (4) @(posedge clk);
      end
      wr(`PSS_CTRL_OFS, 32'h0000_0040);
      power <= 1'b1;
      repeat (20) @(posedge clk);
      chk("disabled", pass, 32'h0);
      wr(`PSS_CTRL_OFS, 32'h0000_0041);
      wait_on(limit, 1'b1);
      repeat (30) @(posedge clk);
      chk("still inrush", limit, 32'h1);
      wait_on(limit, 1'b0);
      chk("aborted", pass, 32'h0);
      rd32(`PSS_STATUS_OFS);
      chk("abort status", rd[4:0], 32'h1b);
      wr(`PSS_STATUS_OFS, 32'h0000_0010);
      chk("wresp", bs, 32'h0);
      rd32(`PSS_STATUS_OFS);
      chk("abort cleared", rd[4:0], 32'h0b);
      power <= 1'b0;
      repeat (8) @(posedge clk);
      rd32(`PSS_STATUS_OFS);
      chk("fault left", rd[1:0], 32'h0);
      end_of_test();
   end
endmodule
